// [rtl/csf_core.v]
`include "csf_defines.vh"

// Notes on behaviour
// - Reset and reload op set stack to 00FF
// - Push decrements, pull increments stack pointer
// - Stack address is page bits plus six
// - Sixty-four deep, wraps silently, overwrites
// - Call pushes two bytes, interrupt five
// - Five-bit code register, each bit testable
// - Add sets half carry from bit three
// - Masked interrupt stays pending until unmasked
// - Negative flag follows result top bit
// - Zero flag set on zero result
// - Carry from ALU, bit tests, shifts
// - Multiply A by X, high to X
// - Multiply takes 11 cycles, clears H, C
// - Decoder covers all five instruction classes
// - Register/memory ops use A or X
// - Branch two bytes, falls through when false
// - Bit set, clear, test in page zero
// - Read-modify-write writes back, test does not
// - Sixteen-bit program counter of next byte
module csf_core #(
  parameter [3:0] MUL_CYCLES = `CSF_MUL_CYCLES
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register port
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Operation request
  input wire op_valid_i,
  input wire [5:0] op_code_i,
  input wire [1:0] op_target_i,
  input wire [1:0] op_len_i,
  input wire [7:0] op_operand_i,
  input wire [15:0] op_ea_i,
  input wire [7:0] op_rel_i,
  input wire [2:0] op_bit_i,
  input wire [3:0] op_cond_i,
  output wire op_ready_o,
  output reg op_done_o,
  output reg op_taken_o,
  // Memory port
  output reg mem_we_o,
  output reg mem_re_o,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  input wire [7:0] mem_rdata_i,
  // Interrupt request
  input wire irq_i,
  input wire [15:0] irq_vector_i,
  output wire irq_pending_o,
  // State view
  output wire [15:0] stack_ptr_o,
  output wire [15:0] program_counter_o,
  output wire [4:0] cond_code_reg_o
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_PUSH = 4'h2;
  localparam [3:0] S_PULL = 4'h4;
  localparam [3:0] S_MUL = 4'h8;
  localparam [3:0] MUL_LOAD = MUL_CYCLES - 4'h2;

  function [1:0] csf_nz;
    input [7:0] r;
    begin
      csf_nz = {r[7], r == 8'h00};
    end
  endfunction

  function csf_cond;
    input [3:0] c;
    input [4:0] f;
    input irq;
    reg base;
    begin
      case (c[3:1])
        3'h0: base = 1'b1;
        3'h1: base = ~(f[`CSF_C] | f[`CSF_Z]);
        3'h2: base = ~f[`CSF_C];
        3'h3: base = ~f[`CSF_Z];
        3'h4: base = ~f[`CSF_H];
        3'h5: base = ~f[`CSF_N];
        3'h6: base = ~f[`CSF_I];
        default: base = irq;
      endcase
      csf_cond = base ^ c[0];
    end
  endfunction

  reg [7:0] a_reg;
  reg [7:0] x_reg;
  reg [4:0] ccr_reg;
  reg [15:0] pc_reg;
  reg [5:0] sp_reg;
  reg [3:0] st_reg;
  reg [3:0] cnt_reg;
  reg [39:0] buf_reg;
  reg rti_reg;
  reg irq_op_reg;
  reg irq_d_reg;
  reg irq_pend_reg;
  reg rd_vld_reg;

  reg [7:0] a_next;
  reg [7:0] x_next;
  reg [4:0] ccr_next;
  reg [15:0] pc_next;
  reg [5:0] sp_next;
  reg [3:0] st_next;
  reg [3:0] cnt_next;
  reg [39:0] buf_next;
  reg we_next;
  reg [15:0] wa_next;
  reg [7:0] wd_next;
  reg taken_next;
  reg [7:0] acc;
  reg cin;
  reg [8:0] sum9;
  reg [8:0] dif9;
  reg [7:0] src;
  reg [7:0] rr;
  reg rc;
  reg rmw_en;

  wire st_idle = st_reg[0];
  wire irq_take = st_idle & irq_pend_reg & ~ccr_reg[`CSF_I];
  wire op_go = op_valid_i & op_ready_o;
  wire go = op_go | irq_take;
  wire [5:0] code = irq_take ? `CSF_OP_IRQ : op_code_i;
  wire [15:0] pc_adv = pc_reg + {14'h0000, op_len_i};
  wire [15:0] br_tgt = pc_adv + {{8{op_rel_i[7]}}, op_rel_i};
  wire [15:0] stack_addr = {`CSF_STACK_PAGE, sp_reg};
  wire [5:0] sp_inc = sp_reg + 6'h01;
  wire [39:0] pull_full = {buf_reg[31:0], mem_rdata_i};
  wire [15:0] page0_ea = {8'h00, op_ea_i[7:0]};

  assign op_ready_o = st_idle & ~irq_take;
  assign irq_pending_o = irq_pend_reg;
  assign stack_ptr_o = stack_addr;
  assign program_counter_o = pc_reg;
  assign cond_code_reg_o = ccr_reg;

  // Read-modify-write result and carry
  always @*
  begin
    src = op_operand_i;
    if (op_target_i == `CSF_TGT_A)
      src = a_reg;
    else if (op_target_i == `CSF_TGT_X)
      src = x_reg;
    rr = src;
    rc = ccr_reg[`CSF_C];
    rmw_en = 1'b1;
    case (code)
      `CSF_OP_INC: rr = src + 8'h01;
      `CSF_OP_DEC: rr = src - 8'h01;
      `CSF_OP_NEG:
      begin
        rr = 8'h00 - src;
        rc = src != 8'h00;
      end
      `CSF_OP_COM:
      begin
        rr = ~src;
        rc = 1'b1;
      end
      `CSF_OP_CLR: rr = 8'h00;
      `CSF_OP_LSR:
      begin
        rr = {1'b0, src[7:1]};
        rc = src[0];
      end
      `CSF_OP_ASR:
      begin
        rr = {src[7], src[7:1]};
        rc = src[0];
      end
      `CSF_OP_ASL:
      begin
        rr = {src[6:0], 1'b0};
        rc = src[7];
      end
      `CSF_OP_ROL:
      begin
        rr = {src[6:0], ccr_reg[`CSF_C]};
        rc = src[7];
      end
      `CSF_OP_ROR:
      begin
        rr = {ccr_reg[`CSF_C], src[7:1]};
        rc = src[0];
      end
      `CSF_OP_TEST: rr = src;
      default: rmw_en = 1'b0;
    endcase
  end

  // Decode of the operation taken this cycle
  always @*
  begin
    a_next = a_reg;
    x_next = x_reg;
    ccr_next = ccr_reg;
    pc_next = pc_adv;
    sp_next = sp_reg;
    st_next = S_IDLE;
    cnt_next = 4'h0;
    buf_next = 40'h0;
    we_next = 1'b0;
    wa_next = op_ea_i;
    wd_next = 8'h00;
    taken_next = 1'b0;
    acc = (code == `CSF_OP_CPX) ? x_reg : a_reg;
    cin = ccr_reg[`CSF_C] & (code == `CSF_OP_ADC || code == `CSF_OP_SBC);
    sum9 = {1'b0, a_reg} + {1'b0, op_operand_i} + {8'h00, cin};
    dif9 = {1'b0, acc} - {1'b0, op_operand_i} - {8'h00, cin};
    case (code)
      `CSF_OP_LDA: a_next = op_operand_i;
      `CSF_OP_LDX: x_next = op_operand_i;
      `CSF_OP_ADD, `CSF_OP_ADC:
      begin
        a_next = sum9[7:0];
        ccr_next[`CSF_C] = sum9[8];
        ccr_next[`CSF_H] = a_reg[4] ^ op_operand_i[4] ^ sum9[4];
      end
      `CSF_OP_SUB, `CSF_OP_SBC:
      begin
        a_next = dif9[7:0];
        ccr_next[`CSF_C] = dif9[8];
      end
      `CSF_OP_CMP, `CSF_OP_CPX: ccr_next[`CSF_C] = dif9[8];
      `CSF_OP_AND: a_next = a_reg & op_operand_i;
      `CSF_OP_ORA: a_next = a_reg | op_operand_i;
      `CSF_OP_EOR: a_next = a_reg ^ op_operand_i;
      `CSF_OP_STA, `CSF_OP_STX:
      begin
        we_next = 1'b1;
        wd_next = (code == `CSF_OP_STX) ? x_reg : a_reg;
      end
      `CSF_OP_JMP: pc_next = op_ea_i;
      `CSF_OP_CALL:
      begin
        pc_next = op_ea_i;
        buf_next = {24'h000000, pc_adv};
        cnt_next = 4'h2;
        st_next = S_PUSH;
      end
      `CSF_OP_BRANCH:
      begin
        taken_next = csf_cond(op_cond_i, ccr_reg, irq_i);
        if (taken_next)
          pc_next = br_tgt;
      end
      `CSF_OP_BSET, `CSF_OP_BCLR:
      begin
        we_next = 1'b1;
        wa_next = page0_ea;
        wd_next = op_operand_i;
        wd_next[op_bit_i] = (code == `CSF_OP_BSET);
      end
      `CSF_OP_BRSET, `CSF_OP_BRCLR:
      begin
        ccr_next[`CSF_C] = op_operand_i[op_bit_i];
        taken_next = op_operand_i[op_bit_i] == (code == `CSF_OP_BRSET);
        if (taken_next)
          pc_next = br_tgt;
      end
      `CSF_OP_SP_RELOAD: sp_next = `CSF_SP_RESET;
      `CSF_OP_SEI: ccr_next[`CSF_I] = 1'b1;
      `CSF_OP_CLI: ccr_next[`CSF_I] = 1'b0;
      `CSF_OP_SEC: ccr_next[`CSF_C] = 1'b1;
      `CSF_OP_CLC: ccr_next[`CSF_C] = 1'b0;
      `CSF_OP_TAX: x_next = a_reg;
      `CSF_OP_TXA: a_next = x_reg;
      `CSF_OP_UMUL:
      begin
        cnt_next = MUL_LOAD;
        st_next = S_MUL;
      end
      `CSF_OP_RTS, `CSF_OP_RTI:
      begin
        cnt_next = (code == `CSF_OP_RTI) ? 4'h5 : 4'h2;
        st_next = S_PULL;
      end
      `CSF_OP_SWI, `CSF_OP_IRQ:
      begin
        // Stacked value is the program counter before the vector jump
        if (code == `CSF_OP_IRQ)
        begin
          pc_next = irq_vector_i;
          buf_next = {3'h7, ccr_reg, a_reg, x_reg, pc_reg};
        end
        else
        begin
          pc_next = op_ea_i;
          buf_next = {3'h7, ccr_reg, a_reg, x_reg, pc_adv};
        end
        ccr_next[`CSF_I] = 1'b1;
        cnt_next = 4'h5;
        st_next = S_PUSH;
      end
      default:
      begin
      end
    endcase
    case (code)
      `CSF_OP_LDA, `CSF_OP_ADD, `CSF_OP_ADC, `CSF_OP_SUB, `CSF_OP_SBC, `CSF_OP_AND, `CSF_OP_ORA,
      `CSF_OP_EOR, `CSF_OP_TXA: ccr_next[`CSF_N:`CSF_Z] = csf_nz(a_next);
      `CSF_OP_LDX, `CSF_OP_TAX: ccr_next[`CSF_N:`CSF_Z] = csf_nz(x_next);
      `CSF_OP_CMP, `CSF_OP_CPX: ccr_next[`CSF_N:`CSF_Z] = csf_nz(dif9[7:0]);
      `CSF_OP_BIT: ccr_next[`CSF_N:`CSF_Z] = csf_nz(a_reg & op_operand_i);
      `CSF_OP_STA, `CSF_OP_STX: ccr_next[`CSF_N:`CSF_Z] = csf_nz(wd_next);
      default:
      begin
      end
    endcase
    if (rmw_en)
    begin
      ccr_next[`CSF_N:`CSF_Z] = csf_nz(rr);
      if (code != `CSF_OP_INC && code != `CSF_OP_DEC && code != `CSF_OP_CLR && code != `CSF_OP_TEST)
        ccr_next[`CSF_C] = rc;
      if (code == `CSF_OP_CLR)
        ccr_next[`CSF_C] = ccr_reg[`CSF_C];
      // Test only reads and sets flags
      if (code != `CSF_OP_TEST)
      begin
        if (op_target_i == `CSF_TGT_A)
          a_next = rr;
        else if (op_target_i == `CSF_TGT_X)
          x_next = rr;
        else
        begin
          we_next = 1'b1;
          wa_next = page0_ea;
          wd_next = rr;
        end
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      a_reg <= 8'h00;
      x_reg <= 8'h00;
      ccr_reg <= `CSF_CCR_RESET;
      pc_reg <= 16'h0000;
      sp_reg <= `CSF_SP_RESET;
      st_reg <= S_IDLE;
      cnt_reg <= 4'h0;
      buf_reg <= 40'h0;
      rti_reg <= 1'b0;
      irq_op_reg <= 1'b0;
      irq_d_reg <= 1'b0;
      irq_pend_reg <= 1'b0;
      rd_vld_reg <= 1'b0;
      reg_rdata_o <= 8'h00;
      op_done_o <= 1'b0;
      op_taken_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
    end
    else
    begin
      op_done_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      rd_vld_reg <= mem_re_o;
      irq_d_reg <= irq_i;
      // New request wins over the clear of the one being serviced
      irq_pend_reg <= (irq_i & ~irq_d_reg) | (irq_pend_reg & ~irq_take);
      reg_rdata_o <= 8'h00;
      if (reg_rd_i)
      begin
        case (reg_addr_i)
          `CSF_REG_A: reg_rdata_o <= a_reg;
          `CSF_REG_X: reg_rdata_o <= x_reg;
          `CSF_REG_CCR: reg_rdata_o <= {3'h0, ccr_reg};
          `CSF_REG_SP: reg_rdata_o <= stack_addr[7:0];
          `CSF_REG_PCL: reg_rdata_o <= pc_reg[7:0];
          `CSF_REG_PCH: reg_rdata_o <= pc_reg[15:8];
          `CSF_REG_STAT: reg_rdata_o <= {6'h00, irq_pend_reg, ~st_idle};
          default: reg_rdata_o <= 8'h00;
        endcase
      end
      case (st_reg)
        S_IDLE:
        begin
          if (go)
          begin
            // Flags commit with the operation so the next one sees them
            a_reg <= a_next;
            x_reg <= x_next;
            ccr_reg <= ccr_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            buf_reg <= buf_next;
            rti_reg <= code == `CSF_OP_RTI;
            irq_op_reg <= irq_take;
            op_taken_o <= taken_next;
            op_done_o <= op_go & (st_next == S_IDLE);
            mem_we_o <= we_next;
            mem_addr_o <= wa_next;
            mem_wdata_o <= wd_next;
          end
          else if (reg_wr_i)
          begin
            // Software writes only land while no operation runs
            case (reg_addr_i)
              `CSF_REG_A: a_reg <= reg_wdata_i;
              `CSF_REG_X: x_reg <= reg_wdata_i;
              `CSF_REG_CCR: ccr_reg <= reg_wdata_i[4:0];
              `CSF_REG_PCL: pc_reg[7:0] <= reg_wdata_i;
              `CSF_REG_PCH: pc_reg[15:8] <= reg_wdata_i;
              default:
              begin
              end
            endcase
          end
        end
        S_PUSH:
        begin
          mem_we_o <= 1'b1;
          mem_addr_o <= stack_addr;
          mem_wdata_o <= buf_reg[7:0];
          buf_reg <= {8'h00, buf_reg[39:8]};
          // Six-bit pointer wraps with no error, overwriting old data
          sp_reg <= sp_reg - 6'h01;
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1)
          begin
            st_reg <= S_IDLE;
            op_done_o <= ~irq_op_reg;
          end
        end
        S_PULL:
        begin
          if (cnt_reg != 4'h0)
          begin
            mem_re_o <= 1'b1;
            mem_addr_o <= {`CSF_STACK_PAGE, sp_inc};
            sp_reg <= sp_inc;
            cnt_reg <= cnt_reg - 4'h1;
          end
          if (rd_vld_reg)
            buf_reg <= pull_full;
          if (rd_vld_reg && cnt_reg == 4'h0 && !mem_re_o)
          begin
            pc_reg <= pull_full[15:0];
            if (rti_reg)
            begin
              ccr_reg <= pull_full[36:32];
              a_reg <= pull_full[31:24];
              x_reg <= pull_full[23:16];
            end
            st_reg <= S_IDLE;
            op_done_o <= 1'b1;
          end
        end
        S_MUL:
        begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h0)
          begin
            {x_reg, a_reg} <= a_reg * x_reg;
            ccr_reg[`CSF_H] <= 1'b0;
            ccr_reg[`CSF_C] <= 1'b0;
            st_reg <= S_IDLE;
            op_done_o <= 1'b1;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

endmodule

// [rtl/csf_defines.vh]
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH

// Stack placement, reset values and multiply length
`define CSF_SP_RESET 6'h3F
`define CSF_STACK_PAGE 10'h003
`define CSF_CCR_RESET 5'h08
`define CSF_MUL_CYCLES 4'hB

// Condition-code bit positions
`define CSF_H 4
`define CSF_I 3
`define CSF_N 2
`define CSF_Z 1
`define CSF_C 0

// Register port offsets
`define CSF_REG_A 4'h0
`define CSF_REG_X 4'h1
`define CSF_REG_CCR 4'h2
`define CSF_REG_SP 4'h3
`define CSF_REG_PCL 4'h4
`define CSF_REG_PCH 4'h5
`define CSF_REG_STAT 4'h6

// Operand targets
`define CSF_TGT_MEM 2'h0
`define CSF_TGT_A 2'h1
`define CSF_TGT_X 2'h2

// Operation codes
`define CSF_OP_LDA 6'h00
`define CSF_OP_LDX 6'h01
`define CSF_OP_ADD 6'h02
`define CSF_OP_ADC 6'h03
`define CSF_OP_SUB 6'h04
`define CSF_OP_SBC 6'h05
`define CSF_OP_AND 6'h06
`define CSF_OP_ORA 6'h07
`define CSF_OP_EOR 6'h08
`define CSF_OP_CMP 6'h09
`define CSF_OP_CPX 6'h0A
`define CSF_OP_BIT 6'h0B
`define CSF_OP_STA 6'h0C
`define CSF_OP_STX 6'h0D
`define CSF_OP_JMP 6'h0E
`define CSF_OP_CALL 6'h0F
`define CSF_OP_BRANCH 6'h10
`define CSF_OP_BSET 6'h11
`define CSF_OP_BCLR 6'h12
`define CSF_OP_BRSET 6'h13
`define CSF_OP_BRCLR 6'h14
`define CSF_OP_INC 6'h15
`define CSF_OP_DEC 6'h16
`define CSF_OP_NEG 6'h17
`define CSF_OP_COM 6'h18
`define CSF_OP_CLR 6'h19
`define CSF_OP_LSR 6'h1A
`define CSF_OP_ASR 6'h1B
`define CSF_OP_ASL 6'h1C
`define CSF_OP_ROL 6'h1D
`define CSF_OP_ROR 6'h1E
`define CSF_OP_TEST 6'h1F
`define CSF_OP_SP_RELOAD 6'h20
`define CSF_OP_SEI 6'h21
`define CSF_OP_CLI 6'h22
`define CSF_OP_SEC 6'h23
`define CSF_OP_CLC 6'h24
`define CSF_OP_TAX 6'h25
`define CSF_OP_TXA 6'h26
`define CSF_OP_NOP 6'h27
`define CSF_OP_UMUL 6'h28
`define CSF_OP_RTS 6'h29
`define CSF_OP_RTI 6'h2A
`define CSF_OP_SWI 6'h2B
`define CSF_OP_IRQ 6'h3F

`endif

// [verification/csf_core_assertions.sv]
`include "csf_defines.vh"
module csf_core_assertions #(
  parameter [3:0] MUL_CYCLES = `CSF_MUL_CYCLES
) (
  // Clock, reset and register port
  input wire clk_i,
  input wire rst_n_i,
  input wire [3:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // Operation port
  input wire op_valid_i,
  input wire [5:0] op_code_i,
  input wire [1:0] op_len_i,
  input wire [7:0] op_operand_i,
  input wire [7:0] op_rel_i,
  input wire [3:0] op_cond_i,
  input wire op_ready_o,
  input wire op_done_o,
  // Memory, interrupt and state
  input wire mem_we_o,
  input wire mem_re_o,
  input wire [15:0] mem_addr_o,
  input wire irq_i,
  input wire [15:0] irq_vector_i,
  input wire irq_pending_o,
  input wire [15:0] stack_ptr_o,
  input wire [15:0] program_counter_o,
  input wire [4:0] cond_code_reg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = op_valid_i && op_ready_o;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_sp_reset:
  assert property (disable iff (1'b0) !rst_n_i |=> stack_ptr_o == 16'h00FF)
    else $error("stack pointer not 00FF after reset");
  chk_sp_page:
  assert property (stack_ptr_o[15:6] == 10'h003)
    else $error("stack pointer left its page");
  chk_pull_page:
  assert property (mem_re_o |-> mem_addr_o[15:6] == 10'h003)
    else $error("stack pull outside stack page");
  chk_call_push:
  assert property (take && op_code_i == `CSF_OP_CALL |=> ##1 mem_we_o
    && mem_addr_o == {10'h003, $past(stack_ptr_o[5:0], 2)}
    ##1 mem_we_o ##1 !mem_we_o && stack_ptr_o[5:0] == $past(stack_ptr_o[5:0], 4) - 6'd2)
    else $error("call did not push two bytes");
  // Figures below hold for the documented multiply length only
  chk_mul_timing:
  assert property (take && op_code_i == `CSF_OP_UMUL && MUL_CYCLES == 4'hB |=> !op_done_o [*8] ##3 op_done_o
    && cond_code_reg_o[4] == 1'b0 && cond_code_reg_o[0] == 1'b0
    && cond_code_reg_o[3:1] == $past(cond_code_reg_o[3:1], 11))
    else $error("multiply timing or flags wrong");
  chk_irq_latch:
  assert property ($rose(irq_i) |=> irq_pending_o)
    else $error("interrupt edge not latched");
  chk_irq_hold:
  assert property (irq_pending_o && cond_code_reg_o[3] |=> irq_pending_o)
    else $error("masked interrupt lost");
  chk_irq_service:
  assert property (irq_pending_o && !cond_code_reg_o[3] |-> ##[1:24] cond_code_reg_o[3]
    && program_counter_o == irq_vector_i)
    else $error("unmasked interrupt not serviced");
  chk_ccr_read:
  assert property (reg_rd_i && reg_addr_i == `CSF_REG_CCR |=> reg_rdata_o == {3'b000, $past(cond_code_reg_o)})
    else $error("condition code read wrong");
  chk_load_flags:
  assert property (take && op_code_i == `CSF_OP_LDA |=> cond_code_reg_o[2:1] == {$past(op_operand_i[7]),
    $past(op_operand_i) == 8'h00})
    else $error("load flags wrong");
  chk_branch_pc:
  assert property (take && op_code_i == `CSF_OP_BRANCH && op_cond_i[3:1] == 3'd0 && op_len_i == 2'd2
    |=> program_counter_o == $past(program_counter_o) + 16'd2
    + ($past(op_cond_i[0]) ? 16'h0000 : {{8{$past(op_rel_i[7])}}, $past(op_rel_i)}))
    else $error("branch target wrong");
endmodule

// [verification/csf_mem_model.sv]
module csf_mem_model (
  // Clock
  input wire clk_i,
  // Core bus
  input wire mem_we_i,
  input wire mem_re_i,
  input wire [15:0] mem_addr_i,
  input wire [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    mem_rdata_o = 8'h00;
  end
  // Read data stands one cycle only; toggling exposes late sampling
  always @(posedge clk_i)
  begin
    if (mem_we_i && mem_addr_i[15:8] == 8'h00)
      mem[mem_addr_i[7:0]] <= mem_wdata_i;
    if (mem_re_i)
      mem_rdata_o <= mem[mem_addr_i[7:0]];
    else
      mem_rdata_o <= ~mem_rdata_o;
  end
endmodule

// [verification/csf_core_test.sv]
`include "csf_defines.vh"
module csf_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] VEC = 16'h1234;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, op_valid_i, irq_i, op_ready_o, op_done_o, op_taken_o;
  logic mem_we_o, mem_re_o, irq_pending_o, t;
  logic [3:0] reg_addr_i, op_cond_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, op_operand_i, op_rel_i, mem_wdata_o, mem_rdata_i, va, vb;
  logic [5:0] op_code_i;
  logic [1:0] op_target_i, op_len_i;
  logic [2:0] op_bit_i;
  logic [15:0] op_ea_i, mem_addr_o, stack_ptr_o, program_counter_o, pc, sp, ret, p;
  logic [4:0] cond_code_reg_o;
  logic [11:0] r;
  logic [31:0] rv;
  wire [15:0] irq_vector_i = VEC;
  int n_fail = 0, n_tests = 0, seed = 84046, cyc;

  csf_core #(.MUL_CYCLES(4'hB)) i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_target_i(op_target_i), .op_len_i(op_len_i), .op_operand_i(op_operand_i),
    .op_ea_i(op_ea_i), .op_rel_i(op_rel_i), .op_bit_i(op_bit_i), .op_cond_i(op_cond_i),
    .op_ready_o(op_ready_o), .op_done_o(op_done_o), .op_taken_o(op_taken_o), .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .irq_i(irq_i), .irq_vector_i(irq_vector_i), .irq_pending_o(irq_pending_o),
    .stack_ptr_o(stack_ptr_o), .program_counter_o(program_counter_o), .cond_code_reg_o(cond_code_reg_o));
  csf_mem_model i_mem (.clk_i(clk_i), .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input [15:0] e, input [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input [3:0] a, input [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input [3:0] a, input [7:0] e, input string nm);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(nm, {8'h00, e}, {8'h00, reg_rdata_o});
  endtask

  // Held until the edge that sees ready, then done awaited
  task automatic op(input [5:0] c, input [1:0] tg, input [1:0] l, input [7:0] v, input [15:0] ea,
                    input [7:0] rl, input [3:0] cn, input [2:0] b);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_target_i <= tg;
    op_len_i <= l;
    op_operand_i <= v;
    op_ea_i <= ea;
    op_rel_i <= rl;
    op_cond_i <= cn;
    op_bit_i <= b;
    @(negedge clk_i);
    while (op_ready_o !== 1'b1)
      @(negedge clk_i);
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    cyc = 0;
    do
    begin
      @(negedge clk_i);
      cyc++;
    end
    while (op_done_o !== 1'b1 && cyc < 40);
    chk("op_done_o", 16'h0001, {15'h0000, op_done_o});
  endtask

  function automatic [11:0] addf(input [7:0] a, input [7:0] b, input ci);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    return {h[4], s[7], s[7:0] == 8'h00, s[8], s[7:0]};
  endfunction

  // Even codes test always, a flag clear or the irq line, odd codes the inverse
  function automatic logic brc(input [3:0] c, input [4:0] f, input q);
    logic [7:0] b;
    b = {q, ~f[3], ~f[2], ~f[4], ~f[1], ~f[0], ~(f[0] | f[1]), 1'b1};
    return b[c[3:1]] ^ c[0];
  endfunction

  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    conclude();
  end

  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, op_valid_i, irq_i, reg_addr_i, reg_wdata_i, op_code_i} = '0;
    {op_target_i, op_len_i, op_operand_i, op_ea_i, op_rel_i, op_bit_i, op_cond_i} = '0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`CSF_REG_A, 8'h00, "acc");
    rd(`CSF_REG_CCR, 8'h08, "ccr");
    rd(`CSF_REG_SP, 8'hFF, "sp");
    rd(4'h7, 8'h00, "unmapped");
    wr(`CSF_REG_SP, 8'h12);
    rd(`CSF_REG_SP, 8'hFF, "sp ro");
    for (int i = 0; i < 24; i++)
    begin
      rv = $random(seed);
      va = (i == 0) ? 8'h0F : (i == 1) ? 8'h80 : rv[7:0];
      vb = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : rv[15:8];
      wr(`CSF_REG_CCR, {7'h00, rv[16]});
      wr(`CSF_REG_A, va);
      op((i % 3 == 0) ? `CSF_OP_ADD : (i % 3 == 1) ? `CSF_OP_ADC : `CSF_OP_LSR, `CSF_TGT_A, 2'd2, vb, 16'h0000,
         8'h00, 4'h0, 3'd0);
      r = (i % 3 == 2) ? {2'b00, va[7:1] == 7'h00, va[0], 1'b0, va[7:1]} : addf(va, vb, i % 3 == 1 && rv[16]);
      chk("ccr", {11'h000, r[11], 1'b0, r[10:8]}, {11'h000, cond_code_reg_o});
      rd(`CSF_REG_A, r[7:0], "acc");
    end
    for (int i = 0; i < 4; i++)
    begin
      rv = $random(seed);
      va = (i == 0) ? 8'hFF : rv[7:0];
      vb = (i == 0) ? 8'hFF : rv[15:8];
      wr(`CSF_REG_A, va);
      wr(`CSF_REG_X, vb);
      wr(`CSF_REG_CCR, {3'b000, rv[20:16]});
      op(`CSF_OP_UMUL, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
      chk("mul cycles", 16'd11, cyc[15:0]);
      chk("mul ccr", {11'h000, 1'b0, rv[19:17], 1'b0}, {11'h000, cond_code_reg_o});
      p = va * vb;
      rd(`CSF_REG_X, p[15:8], "mul hi");
      rd(`CSF_REG_A, p[7:0], "mul lo");
    end
    for (int c = 0; c < 16; c++)
    begin
      rv = $random(seed);
      wr(`CSF_REG_CCR, {3'b000, rv[4:0]});
      pc = program_counter_o;
      op(`CSF_OP_BRANCH, `CSF_TGT_A, 2'd2, 8'h00, 16'h0000, rv[15:8], c[3:0], 3'd0);
      t = brc(c[3:0], rv[4:0], irq_i);
      chk("taken", {15'h0000, t}, {15'h0000, op_taken_o});
      chk("pc", pc + 16'd2 + (t ? {{8{rv[15]}}, rv[15:8]} : 16'h0000), program_counter_o);
    end
    op(`CSF_OP_SP_RELOAD, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
    chk("sp", 16'h00FF, stack_ptr_o);
    // 66 bytes pushed: the last call lands on the first one
    for (int k = 0; k < 33; k++)
    begin
      rv = $random(seed);
      ret = program_counter_o + 16'd3;
      op(`CSF_OP_CALL, `CSF_TGT_MEM, 2'd3, 8'h00, rv[15:0], 8'h00, 4'h0, 3'd0);
      chk("pc", rv[15:0], program_counter_o);
    end
    chk("sp", 16'h00FD, stack_ptr_o);
    @(negedge clk_i);
    chk("push lo", {8'h00, ret[7:0]}, {8'h00, i_mem.mem[8'hFF]});
    chk("push hi", {8'h00, ret[15:8]}, {8'h00, i_mem.mem[8'hFE]});
    op(`CSF_OP_RTS, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
    chk("pc", ret, program_counter_o);
    chk("sp", 16'h00FF, stack_ptr_o);
    rv = $random(seed);
    va = rv[7:0];
    vb = rv[15:8];
    op(`CSF_OP_LDA, `CSF_TGT_A, 2'd2, va, 16'h0000, 8'h00, 4'h0, 3'd0);
    op(`CSF_OP_STA, `CSF_TGT_MEM, 2'd2, 8'h00, 16'h0040, 8'h00, 4'h0, 3'd0);
    op(`CSF_OP_BSET, `CSF_TGT_MEM, 2'd2, vb, 16'h0041, 8'h00, 4'h0, rv[18:16]);
    chk("store", {8'h00, va}, {8'h00, i_mem.mem[8'h40]});
    op(`CSF_OP_BRSET, `CSF_TGT_MEM, 2'd3, vb, 16'h0041, 8'h10, 4'h0, rv[18:16]);
    chk("bit set", {8'h00, vb | (8'h01 << rv[18:16])}, {8'h00, i_mem.mem[8'h41]});
    chk("bit carry", {15'h0000, vb[rv[18:16]]}, {15'h0000, cond_code_reg_o[0]});
    chk("bit taken", {15'h0000, vb[rv[18:16]]}, {15'h0000, op_taken_o});
    op(`CSF_OP_TEST, `CSF_TGT_MEM, 2'd2, va, 16'h0040, 8'h00, 4'h0, 3'd0);
    chk("test mem", {8'h00, va}, {8'h00, i_mem.mem[8'h40]});
    chk("test nz", {14'h0000, va[7], va == 8'h00}, {14'h0000, cond_code_reg_o[2:1]});
    op(`CSF_OP_INC, `CSF_TGT_MEM, 2'd2, vb, 16'h0042, 8'h00, 4'h0, 3'd0);
    op(`CSF_OP_SEI, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
    chk("inc mem", {8'h00, vb + 8'h01}, {8'h00, i_mem.mem[8'h42]});
    @(posedge clk_i);
    irq_i <= 1'b1;
    @(posedge clk_i);
    irq_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    chk("pending", 16'h0001, {15'h0000, irq_pending_o});
    sp = stack_ptr_o;
    op(`CSF_OP_CLI, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
    pc = program_counter_o;
    repeat (8) @(negedge clk_i);
    chk("vector", VEC, program_counter_o);
    chk("mask", 16'h0001, {15'h0000, cond_code_reg_o[3]});
    chk("irq sp", {sp[15:6], sp[5:0] - 6'd5}, stack_ptr_o);
    chk("stacked ccr", 16'h0007, {13'h0000, i_mem.mem[{2'b11, sp[5:0] - 6'd4}][7:5]});
    op(`CSF_OP_RTI, `CSF_TGT_A, 2'd1, 8'h00, 16'h0000, 8'h00, 4'h0, 3'd0);
    chk("return", pc, program_counter_o);
    chk("sp", sp, stack_ptr_o);
    conclude();
  end
endmodule

bind csf_core csf_core_assertions #(.MUL_CYCLES(MUL_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_len_i(op_len_i), .op_operand_i(op_operand_i),
  .op_rel_i(op_rel_i), .op_cond_i(op_cond_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
  .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_addr_o(mem_addr_o), .irq_i(irq_i),
  .irq_vector_i(irq_vector_i), .irq_pending_o(irq_pending_o), .stack_ptr_o(stack_ptr_o),
  .program_counter_o(program_counter_o), .cond_code_reg_o(cond_code_reg_o));
